// [common/twm_pkg.sv]
`default_nettype none
package twm_pkg;

    // ==================================================================
    // Timing
    localparam int CLK_HZ   = 250_000_000;
    localparam int RATE0_HZ = 100_000;
    localparam int RATE1_HZ = 400_000;
    localparam int RATE2_HZ = 800_000;
    localparam int RATE3_HZ = 1_000_000;
    localparam int QW       = 10;
    // Quarter bit periods in clock cycles, fractions round down
    localparam logic [QW-1:0] QTR0 = QW'(CLK_HZ / (4 * RATE0_HZ));
    localparam logic [QW-1:0] QTR1 = QW'(CLK_HZ / (4 * RATE1_HZ));
    localparam logic [QW-1:0] QTR2 = QW'(CLK_HZ / (4 * RATE2_HZ));
    localparam logic [QW-1:0] QTR3 = QW'(CLK_HZ / (4 * RATE3_HZ));

    // ==================================================================
    // Sizes and fixed positions
    localparam int             CW        = 5;
    localparam logic [CW-1:0]  MAX_BYTES = 5'h10;
    localparam logic [CW-1:0]  ONE_BYTE  = 5'h01;
    localparam logic [3:0]     ACK_SLOT  = 4'h8;
    localparam logic [1:0]     Q_FIRST   = 2'h0;
    localparam logic [1:0]     Q_DRIVE   = 2'h1;
    localparam logic [1:0]     Q_SAMPLE  = 2'h2;
    localparam logic [1:0]     Q_LAST    = 2'h3;
    localparam int             FIFO_W    = 8;
    localparam int             FIFO_D    = 8;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {
        TWM_RD, TWM_WR, TWM_RD_WR, TWM_WR_RD
    } twm_xfer_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_BUSWAIT, ST_START, ST_BIT, ST_LOAD, ST_STOP, ST_DONE
    } twm_state_t;

    typedef struct packed {
        twm_xfer_t     xfer;
        logic [1:0]    rate;
        logic [6:0]    addr;
        logic [CW-1:0] wr_cnt;
        logic [CW-1:0] rd_cnt;
    } twm_cfg_t;

    // ==================================================================
    // Helpers
    function automatic logic [QW-1:0] qtr_len(input logic [1:0] r);
        case (r)
            2'h0:    qtr_len = QTR0;
            2'h1:    qtr_len = QTR1;
            2'h2:    qtr_len = QTR2;
            default: qtr_len = QTR3;
        endcase
    endfunction : qtr_len

    function automatic logic [CW-1:0] clamp_cnt(input logic [CW-1:0] c);
        if (c == '0)
            clamp_cnt = ONE_BYTE;
        else if (c > MAX_BYTES)
            clamp_cnt = MAX_BYTES;
        else
            clamp_cnt = c;
    endfunction : clamp_cnt

    function automatic logic first_rd(input twm_xfer_t x);
        first_rd = (x == TWM_RD) || (x == TWM_RD_WR);
    endfunction : first_rd

    function automatic logic two_phase(input twm_xfer_t x);
        two_phase = (x == TWM_RD_WR) || (x == TWM_WR_RD);
    endfunction : two_phase

endpackage : twm_pkg
`default_nettype wire

// [design/twm_core.sv]
`timescale 1ns/100ps
`default_nettype none
module twm_core (
    input  wire logic            clk_i,       // 250 MHz clock
    input  wire logic            sys_rst_i,   // Sync reset, high
    input  wire logic            enable_i,    // Block enable
    input  wire logic            start_i,     // Start pulse
    input  wire twm_pkg::twm_cfg_t cfg_i,     // Transfer setup
    output var  logic            busy_o,      // Transfer running
    output var  logic            done_o,      // Completion pulse
    output var  logic            nack_o,      // No-ack seen
    output var  logic            clk_req_o,   // Peripheral clock request
    input  wire logic [7:0]      tx_data_i,   // Byte to send
    input  wire logic            tx_valid_i,  // Byte to send valid
    output var  logic            tx_ready_o,  // Byte taken
    output var  logic [7:0]      rx_data_o,   // Received byte
    output var  logic            rx_valid_o,  // Received byte valid
    input  wire logic            rx_ready_i,  // Received byte taken
    input  wire logic            scl_i,       // Clock wire level
    output var  logic            scl_o,       // Clock wire drive value
    output var  logic            scl_oe_o,    // Clock wire pulled low
    input  wire logic            sda_i,       // Data wire level
    output var  logic            sda_o,       // Data wire drive value
    output var  logic            sda_oe_o     // Data wire pulled low
);
    import twm_pkg::*;

    typedef struct packed {
        twm_state_t    st;
        twm_cfg_t      cfg;
        logic [1:0]    q;
        logic [QW-1:0] cnt;
        logic [3:0]    bitn;
        logic [7:0]    sh;
        logic          smp;
        logic          second;
        logic          rd;
        logic          addr_ph;
        logic [CW-1:0] remain;
        logic          nack;
        logic          scl_oe;
        logic          sda_oe;
        logic          busy;
        logic          done;
        logic          tx_ready;
        logic          rx_push;
        logic [7:0]    rx_data;
        logic          clk_req;
        logic          sda_m;
        logic          sda_s;
        logic          scl_m;
        logic          scl_s;
    } twm_core_st_t;

    twm_core_st_t s_r;
    twm_core_st_t s_nxt;
    logic         rx_space;

    // ==================================================================
    // Receive buffer toward the user
    twm_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_data_i   (s_r.rx_data),
        .in_valid_i  (s_r.rx_push),
        .in_ready_o  (rx_space),
        .out_data_o  (rx_data_o),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i)
    );

    // ==================================================================
    // Transfer sequencer
    always_comb begin
        logic tick;
        logic q_end;
        logic bitval;
        logic rd_data;
        s_nxt   = s_r;
        bitval  = 1'b1;
        tick    = s_r.cnt == '0;
        q_end   = tick && (s_r.q == Q_LAST);
        rd_data = s_r.rd && !s_r.addr_ph;
        s_nxt.done    = 1'b0;
        s_nxt.rx_push = 1'b0;
        s_nxt.tx_ready = 1'b0;
        // Pin synchronisers
        s_nxt.sda_m = sda_i;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.scl_m = scl_i;
        s_nxt.scl_s = s_r.scl_m;
        // Bit value for the current slot; master acks all but last read
        if (s_r.bitn == ACK_SLOT)
            bitval = rd_data ? (s_r.remain == ONE_BYTE) : 1'b1;
        else
            bitval = rd_data ? 1'b1 : s_r.sh[7];
        // Quarter timer runs only while timing bus phases
        if (s_r.st == ST_START || s_r.st == ST_BIT || s_r.st == ST_STOP) begin
            if (tick) begin
                s_nxt.cnt = qtr_len(s_r.cfg.rate) - 1'b1;
                s_nxt.q   = s_r.q + 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.scl_oe = 1'b0;
                s_nxt.sda_oe = 1'b0;
                s_nxt.busy   = 1'b0;
                if (start_i && enable_i) begin
                    s_nxt.cfg    = cfg_i;
                    s_nxt.busy   = 1'b1;
                    s_nxt.nack   = 1'b0;
                    s_nxt.second = 1'b0;
                    s_nxt.rd     = first_rd(cfg_i.xfer);
                    s_nxt.st     = ST_BUSWAIT;
                end
            end
            ST_BUSWAIT: begin
                // Both wires idle high; no contention check beyond this
                if (s_r.scl_s && s_r.sda_s) begin
                    s_nxt.st  = ST_START;
                    s_nxt.q   = Q_FIRST;
                    s_nxt.cnt = qtr_len(s_r.cfg.rate) - 1'b1;
                end
            end
            ST_START: begin
                // Clock low, release both, data falls, clock falls
                s_nxt.scl_oe = (s_r.q == Q_FIRST) || (s_r.q == Q_LAST);
                s_nxt.sda_oe = s_r.q[1];
                if (q_end) begin
                    s_nxt.st      = ST_BIT;
                    s_nxt.q       = Q_FIRST;
                    s_nxt.bitn    = '0;
                    s_nxt.sh      = {s_r.cfg.addr, s_r.rd};
                    s_nxt.addr_ph = 1'b1;
                end
            end
            ST_BIT: begin
                // Clock low for two quarters, high for two; never waits
                s_nxt.scl_oe = !s_r.q[1];
                if (s_r.q == Q_DRIVE)
                    s_nxt.sda_oe = !bitval;
                if (tick && s_r.q == Q_SAMPLE)
                    s_nxt.smp = s_r.sda_s;
                if (q_end) begin
                    s_nxt.q    = Q_FIRST;
                    s_nxt.bitn = s_r.bitn + 1'b1;
                    if (s_r.bitn != ACK_SLOT) begin
                        s_nxt.sh = {s_r.sh[6:0], s_r.smp};
                    end else if (!rd_data && s_r.smp) begin
                        s_nxt.nack = 1'b1;
                        s_nxt.st   = ST_STOP;
                    end else if (s_r.addr_ph) begin
                        s_nxt.addr_ph = 1'b0;
                        s_nxt.remain  = clamp_cnt(s_r.rd ? s_r.cfg.rd_cnt
                                                         : s_r.cfg.wr_cnt);
                        s_nxt.st      = ST_LOAD;
                    end else begin
                        if (s_r.rd) begin
                            s_nxt.rx_push = 1'b1;
                            s_nxt.rx_data = s_r.sh;
                        end
                        s_nxt.remain = s_r.remain - 1'b1;
                        if (s_r.remain != ONE_BYTE) begin
                            s_nxt.st = ST_LOAD;
                        end else if (two_phase(s_r.cfg.xfer) && !s_r.second) begin
                            s_nxt.second = 1'b1;
                            s_nxt.rd     = !s_r.rd;
                            s_nxt.st     = ST_START;
                        end else begin
                            s_nxt.st = ST_STOP;
                        end
                    end
                end
            end
            ST_LOAD: begin
                // Hold clock low until a byte or buffer room is there
                s_nxt.scl_oe = 1'b1;
                s_nxt.q      = Q_FIRST;
                s_nxt.bitn   = '0;
                s_nxt.cnt    = qtr_len(s_r.cfg.rate) - 1'b1;
                if (s_r.rd) begin
                    // Let a pending push land before trusting the room flag
                    if (rx_space && !s_r.rx_push)
                        s_nxt.st = ST_BIT;
                end else if (s_r.tx_ready && tx_valid_i) begin
                    s_nxt.sh = tx_data_i;
                    s_nxt.st = ST_BIT;
                end else begin
                    s_nxt.tx_ready = 1'b1;
                end
            end
            ST_STOP: begin
                // Clock falls, data falls under a low clock, clock rises,
                // data rises; data never moves in the same cycle as clock
                s_nxt.scl_oe = !s_r.q[1];
                if (s_r.q == Q_DRIVE)
                    s_nxt.sda_oe = 1'b1;
                else if (s_r.q == Q_LAST)
                    s_nxt.sda_oe = 1'b0;
                if (q_end)
                    s_nxt.st = ST_DONE;
            end
            default: begin
                s_nxt.done = 1'b1;
                s_nxt.busy = 1'b0;
                s_nxt.st   = ST_IDLE;
            end
        endcase
        // Disable abandons any transfer and frees the wires
        if (!enable_i) begin
            s_nxt.st       = ST_IDLE;
            s_nxt.scl_oe   = 1'b0;
            s_nxt.sda_oe   = 1'b0;
            s_nxt.busy     = 1'b0;
            s_nxt.tx_ready = 1'b0;
        end
        // Request the shared clock only while enabled and working
        s_nxt.clk_req = enable_i && (s_nxt.st != ST_IDLE);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // ==================================================================
    // Outputs
    assign busy_o     = s_r.busy;
    assign done_o     = s_r.done;
    assign nack_o     = s_r.nack;
    assign clk_req_o  = s_r.clk_req;
    assign tx_ready_o = s_r.tx_ready;
    assign scl_o      = 1'b0; // Open drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign scl_oe_o   = s_r.scl_oe;
    assign sda_oe_o   = s_r.sda_oe;

endmodule : twm_core
`default_nettype wire

// [design/twm_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module twm_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,       // Clock
    input  wire logic         sys_rst_i,   // Sync reset, high
    input  wire logic [W-1:0] in_data_i,   // Write word
    input  wire logic         in_valid_i,  // Write request
    output var  logic         in_ready_o,  // Room for a word
    output var  logic [W-1:0] out_data_o,  // Head word
    output var  logic         out_valid_o, // Head word present
    input  wire logic         out_ready_i  // Head word taken
);
    localparam int FCW = $clog2(D + 1);
    localparam logic [FCW-1:0] FULL_CNT = FCW'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [FCW-1:0]      count;
        logic                valid;
        logic                full;
    } twm_fifo_st_t;

    twm_fifo_st_t s_r;
    twm_fifo_st_t s_nxt;

    // ==================================================================
    // Shift-register queue: the head always sits in slot 0
    always_comb begin
        logic           push;
        logic           pop;
        logic [FCW-1:0] idx;
        s_nxt = s_r;
        pop   = s_r.valid && out_ready_i;
        push  = !s_r.full && in_valid_i;
        idx   = s_r.count - FCW'(pop);
        if (pop) begin
            for (int i = 0; i < D - 1; i++) begin
                s_nxt.mem[i] = s_r.mem[i + 1];
            end
        end
        if (push) begin
            s_nxt.mem[idx] = in_data_i;
        end
        s_nxt.count = s_r.count + FCW'(push) - FCW'(pop);
        s_nxt.valid = s_nxt.count != '0;
        s_nxt.full  = s_nxt.count == FULL_CNT;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign in_ready_o  = !s_r.full;
    assign out_data_o  = s_r.mem[0];
    assign out_valid_o = s_r.valid;

endmodule : twm_fifo
`default_nettype wire

// [dv/twm_checker_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module twm_checker (
    input wire logic       clk_i,      // Clock
    input wire logic       sys_rst_i,  // Sync reset
    input wire logic       enable_i,   // Block enable
    input wire logic       start_i,    // Start request
    input wire logic       busy_o,     // Transfer running
    input wire logic       done_o,     // Completion pulse
    input wire logic       nack_o,     // No-ack flag
    input wire logic       clk_req_o,  // Clock request
    input wire logic       tx_valid_i, // Write byte valid
    input wire logic       tx_ready_o, // Write byte taken
    input wire logic [7:0] rx_data_o,  // Read byte
    input wire logic       rx_valid_o, // Read byte valid
    input wire logic       rx_ready_i, // Read byte taken
    input wire logic       scl_oe_o,   // Clock wire pulled low
    input wire logic       sda_oe_o    // Data wire pulled low
);
    // ==================================================================
    // Clocking and accepted start
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic acc;
    assign acc = start_i && enable_i && !busy_o;

    // ==================================================================
    // Properties
    a_req_off: assert property (!enable_i |=> !clk_req_o)
        else $error("clock request while disabled");
    a_req_busy: assert property (busy_o |-> clk_req_o)
        else $error("busy without clock request");
    a_start_busy: assert property (acc |=> busy_o && !nack_o)
        else $error("start not taken or flag kept");
    a_done_pulse: assert property (
        done_o |-> !busy_o && $past(busy_o) ##1 !done_o)
        else $error("done not a single pulse ending busy");
    a_idle_free: assert property (!busy_o |-> !scl_oe_o && !sda_oe_o)
        else $error("wire pulled low while idle");
    a_nack_busy: assert property ($rose(nack_o) |-> busy_o)
        else $error("no-ack flag outside a transfer");
    a_tx_hold: assert property (
        tx_ready_o && !tx_valid_i && enable_i |=> tx_ready_o)
        else $error("write ready withdrawn");
    a_tx_take: assert property (tx_ready_o && tx_valid_i |=> !tx_ready_o)
        else $error("write ready kept after take");
    a_rx_hold: assert property (rx_valid_o && !rx_ready_i
        |=> rx_valid_o && $stable(rx_data_o))
        else $error("read byte changed before take");

    // Main scenarios reached
    c_nack: cover property (done_o && nack_o);
    c_tx: cover property (tx_ready_o && tx_valid_i);
    c_rx: cover property (rx_valid_o && rx_ready_i);
endmodule : twm_checker

bind twm_core twm_checker i_twm_checker (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
    .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
    .clk_req_o(clk_req_o), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o)
);
`default_nettype wire

// [dv/twm_slave_model.sv]
`timescale 1ns/100ps
`default_nettype none
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h52
) (
    input  wire logic scl_i,   // Clock wire level
    input  wire logic sda_i,   // Data wire level
    input  wire logic nack_i,  // Refuse written bytes
    output var  logic sda_oe_o // Pull data wire low
);
    logic [7:0] mem [0:15];
    logic [7:0] sh, tb;
    logic       act = 0, aph = 1, rd = 0, ok = 0, mack = 1;
    int         bitn = 0, wn = 0, rix = 0, starts = 0, stops = 0, macks = 0;
    initial sda_oe_o = 1'b0;

    // Start and stop are data edges while the clock is high
    always @(negedge sda_i) if (scl_i) begin
        starts++;
        act = 1;
        aph = 1;
        bitn = 0;
        wn = 0;
        rix = 0;
    end
    always @(posedge sda_i) if (scl_i) begin
        stops++;
        act = 0;
    end
    // Bits and the master's ack are taken on the rising clock
    always @(posedge scl_i) if (act) begin
        if (bitn < 8) sh = {sh[6:0], sda_i};
        else mack = sda_i;
        bitn++;
    end
    // Data changes only while the clock is low
    always @(negedge scl_i) if (act) begin
        if (bitn == 9) begin
            bitn = 0;
            if (aph) aph = 0;
            else if (rd) begin
                macks += 32'(!mack);
                rix++;
                ok = !mack;
            end else if (ok) begin
                mem[wn] = sh;
                wn++;
            end
        end
        if (bitn == 8 && aph) begin
            rd = sh[0];
            ok = sh[7:1] == ADDR;
        end
        tb = 8'h3c + rix[7:0];
        if (bitn == 8) sda_oe_o = (rd && !aph) ? 1'b0 : ok && (aph || !nack_i);
        else sda_oe_o = ok && rd && !aph && !tb[7 - bitn];
    end
endmodule : twm_slave_model
`default_nettype wire

// [dv/two_wire_master_controller_test.sv]
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_controller_test;
    import twm_pkg::*;
    localparam int         LIMIT = 98000;
    localparam logic [6:0] SLV   = 7'h52;
    logic       clk_i = 0, sys_rst_i = 1, enable_i = 1, start_i = 0;
    twm_cfg_t   cfg_i = '0;
    logic [7:0] tx_data_i = 8'h00, rx_data_o;
    logic       tx_valid_i = 0, rx_ready_i = 0, rx_en = 0, slv_nack = 0;
    logic       busy_o, done_o, nack_o, clk_req_o, tx_ready_o, rx_valid_o;
    logic       scl_oe_o, sda_oe_o, slv_oe, scl_w, sda_w, oe_d = 0;
    logic [7:0] txq[$], rxq[$];
    int         error_cnt = 0, num_checks = 0, cyc = 0, last = 0;
    int         fits = 0, qlen = 1, s0, p0, m0;

    // ==================================================================
    // Clock, open-drain wires with pull-ups, design and far side
    always #2 clk_i = !clk_i;
    assign scl_w = !scl_oe_o;
    assign sda_w = !sda_oe_o && !slv_oe;
    twm_core i_twm_core (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
        .start_i(start_i), .cfg_i(cfg_i), .busy_o(busy_o), .done_o(done_o),
        .nack_o(nack_o), .clk_req_o(clk_req_o), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .scl_i(scl_w), .scl_o(),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o)
    );
    twm_slave_model #(.ADDR(SLV)) i_twm_slave_model (
        .scl_i(scl_w), .sda_i(sda_w), .nack_i(slv_nack), .sda_oe_o(slv_oe)
    );

    // Byte streams and a count of clock periods of exactly 4Q
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) void'(txq.pop_front());
        if (rx_valid_o && rx_ready_i) rxq.push_back(rx_data_o);
        if (scl_oe_o && !oe_d) begin
            if (cyc - last == 4 * qlen) fits++;
            last = cyc;
        end
        oe_d = scl_oe_o;
        cyc++;
        #1;
        tx_valid_i = txq.size() > 0;
        tx_data_i = txq.size() > 0 ? txq[0] : 8'h00;
        rx_ready_i = rx_en;
    end
    // Hang guard
    always @(posedge clk_i) if (cyc == LIMIT) begin
        error_cnt++;
        wrap_up();
    end

    // ==================================================================
    // Shared tasks
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk

    task automatic go(input twm_xfer_t x, input logic [1:0] r,
                      input logic [6:0] a, input logic [4:0] w, n);
        int hz [4] = '{100000, 400000, 800000, 1000000};
        @(posedge clk_i);
        #1;
        cfg_i = '{x, r, a, w, n};
        start_i = 1'b1;
        qlen = 250000000 / (4 * hz[r]);
        fits = 0;
        s0 = i_twm_slave_model.starts;
        p0 = i_twm_slave_model.stops;
        m0 = i_twm_slave_model.macks;
        @(posedge clk_i);
        #1;
        start_i = 1'b0;
        chk(busy_o, "busy not raised");
        chk(clk_req_o === 1'b1, "no clock request while busy");
    endtask : go

    task automatic fin(input logic nk, input int st);
        while (done_o !== 1'b1) @(posedge clk_i) #1;
        chk(busy_o === 1'b0, "busy kept at done");
        chk(nack_o === nk, "no-ack flag");
        chk(i_twm_slave_model.starts - s0 == st, "start count");
        chk(i_twm_slave_model.stops - p0 == 1, "stop count");
        chk(fits >= 8, "bit rate");
        repeat (20) @(posedge clk_i);
    endtask : fin

    // ==================================================================
    // Scenarios
    task automatic t_off;
        enable_i = 1'b0;
        start_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 start_i = 1'b0;
        chk(busy_o === 1'b0, "start taken while off");
        chk(clk_req_o === 1'b0, "clock request while off");
        enable_i = 1'b1;
        $display("test off done");
    endtask : t_off

    task automatic t_nack_addr;
        txq.push_back(8'h11);
        go(TWM_WR, 2'h0, 7'h15, 5'h01, 5'h01);
        fin(1'b1, 1);
        chk(txq.size() == 1, "byte sent after no-ack");
        txq.delete();
        $display("test address no-ack done");
    endtask : t_nack_addr

    task automatic t_wr_nack;
        slv_nack = 1'b1;
        txq = '{8'ha5, 8'h5a};
        go(TWM_WR, 2'h1, SLV, 5'h02, 5'h01);
        fin(1'b1, 1);
        chk(i_twm_slave_model.mem[0] === 8'ha5, "written byte");
        chk(txq.size() == 1, "byte sent after no-ack");
        txq.delete();
        slv_nack = 1'b0;
        $display("test write no-ack done");
    endtask : t_wr_nack

    task automatic t_read_fill;
        go(TWM_RD, 2'h3, SLV, 5'h01, 5'h09);
        repeat (22000) @(posedge clk_i);
        chk(busy_o === 1'b1, "ran on past a full buffer");
        rx_en = 1'b1;
        fin(1'b0, 1);
        chk(rxq.size() == 9, "read count");
        foreach (rxq[i]) chk(rxq[i] === 8'h3c + 8'(i), "read byte");
        chk(i_twm_slave_model.macks - m0 == 8, "master acks");
        rxq.delete();
        $display("test read fill done");
    endtask : t_read_fill

    task automatic t_wr_rd;
        txq.push_back(8'h07);
        go(TWM_WR_RD, 2'h2, SLV, 5'h01, 5'h02);
        fin(1'b0, 2);
        chk(i_twm_slave_model.mem[0] === 8'h07, "pointer byte");
        chk(rxq.size() == 2 && rxq[1] === 8'h3d, "read after write");
        rxq.delete();
        $display("test write-read done");
    endtask : t_wr_rd

    task automatic t_rd_wr;
        txq.push_back(8'h96);
        go(TWM_RD_WR, 2'h3, SLV, 5'h01, 5'h01);
        fin(1'b0, 2);
        chk(rxq.size() == 1 && rxq[0] === 8'h3c, "read before write");
        chk(i_twm_slave_model.mem[0] === 8'h96, "write after read");
        rxq.delete();
        $display("test read-write done");
    endtask : t_rd_wr

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        t_off();
        t_nack_addr();
        t_wr_nack();
        t_read_fill();
        t_wr_rd();
        t_rd_wr();
        wrap_up();
    end
endmodule : two_wire_master_controller_test
`default_nettype wire
